// [src/rsl_pkg.sv]
// Constants and types shared by the strap option loader
package rsl_pkg;

    // Avalon-MM register window
    localparam int          RSL_ADDR_W         = 4;
    localparam int          RSL_DATA_W         = 32;
    localparam logic [3:0]  RSL_REG_STATUS_OFS = 4'h0;
    localparam logic [3:0]  RSL_REG_CTRL_OFS   = 4'h4;
    localparam logic [3:0]  RSL_REG_CONFIG_OFS = 4'h8;

    // Status register fields
    localparam int          RSL_STAT_XOR_BIT    = 0;
    localparam int          RSL_STAT_ALLZ_BIT   = 1;
    localparam int          RSL_STAT_FREQ_BIT   = 2;
    localparam int          RSL_STAT_QD_BIT     = 3;
    localparam int          RSL_STAT_VALID_BIT  = 4;
    localparam int          RSL_STAT_XACT_BIT   = 5;
    localparam int          RSL_STAT_COLD_BIT   = 6;

    // Control register fields and reset value
    localparam int          RSL_CTRL_DRIVE_BIT  = 0;
    localparam logic [31:0] RSL_CTRL_RESET      = 32'h00000001;

    // Config register fields
    localparam int          RSL_CFG_QD_LSB      = 0;
    localparam int          RSL_CFG_MHZ_LSB     = 8;

    // Decoded option values
    localparam int          RSL_QD_W            = 3;
    localparam logic [2:0]  RSL_QD_DEEP         = 3'h4;
    localparam logic [2:0]  RSL_QD_SHALLOW      = 3'h1;
    localparam logic [7:0]  RSL_HOST_MHZ_SLOW   = 8'h42;
    localparam logic [7:0]  RSL_HOST_MHZ_FAST   = 8'h64;

    // Strap reset values before any cold reset is seen
    localparam logic        RSL_STRAP_RESET     = 1'b0;
    localparam logic        RSL_PRST_PREV_RESET = 1'b1;

    typedef enum logic [1:0] {
        RSL_ST_COLD = 2'b01,
        RSL_ST_RUN  = 2'b10
    } rsl_state_t;

    // Queue-depth strap: 0 gives four entries, 1 gives one
    function automatic logic [2:0] rsl_depth(input logic strap);
        return strap ? RSL_QD_SHALLOW : RSL_QD_DEEP;
    endfunction

    // Frequency strap: 0 gives 66 MHz, 1 gives 100 MHz
    function automatic logic [7:0] rsl_host_mhz(input logic strap);
        return strap ? RSL_HOST_MHZ_FAST : RSL_HOST_MHZ_SLOW;
    endfunction

endpackage

// [src/rsl_cfg_if.sv]
// Latched strap options passed from capture to register file
`timescale 1ns/100ps
`default_nettype none
interface rsl_cfg_if;
    logic xor_strap;
    logic allz_strap;
    logic freq_strap;
    logic qd_strap;
    logic xor_active;
    logic cold;
    logic valid;

    modport src (output xor_strap, allz_strap, freq_strap, qd_strap,
                 xor_active, cold, valid);
    modport dst (input  xor_strap, allz_strap, freq_strap, qd_strap,
                 xor_active, cold, valid);
endinterface
`default_nettype wire

// [src/rsl_strap_capture.sv]
// Strap sampling during cold reset and latching after it
`timescale 1ns/100ps
`default_nettype none
module rsl_strap_capture
    import rsl_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  reset,
    // Board resets and straps
    input  wire logic  global_reset_n,
    input  wire logic  processor_reset_n,
    input  wire logic  strap_xor_test,
    input  wire logic  strap_all_z,
    input  wire logic  strap_host_freq,
    input  wire logic  strap_queue_depth,
    // Latched options
    rsl_cfg_if.src     cfg
);

    rsl_state_t state_r;
    rsl_state_t state_nxt;
    logic       xor_r;
    logic       allz_r;
    logic       freq_r;
    logic       qd_r;
    logic       qd_locked_r;
    logic       prst_prev_r;
    logic       prst_rise;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RSL_ST_COLD: if (global_reset_n) state_nxt = RSL_ST_RUN;
            RSL_ST_RUN:  if (!global_reset_n) state_nxt = RSL_ST_COLD;
            default:     state_nxt = RSL_ST_COLD;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= RSL_ST_COLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Follow the straps while cold, freeze at release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xor_r  <= RSL_STRAP_RESET;
            allz_r <= RSL_STRAP_RESET;
            freq_r <= RSL_STRAP_RESET;
        end else if (!global_reset_n) begin
            xor_r  <= strap_xor_test;
            allz_r <= strap_all_z;
            freq_r <= strap_host_freq;
        end
    end

    assign prst_rise = processor_reset_n & ~prst_prev_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prst_prev_r <= RSL_PRST_PREV_RESET;
        end else begin
            prst_prev_r <= processor_reset_n;
        end
    end

    // Warm processor resets must not disturb the depth once taken
    always_ff @(posedge clk_sys) begin
        if (reset || !global_reset_n) begin
            qd_r        <= RSL_STRAP_RESET;
            qd_locked_r <= 1'b0;
        end else if (prst_rise && !qd_locked_r) begin
            qd_r        <= strap_queue_depth;
            qd_locked_r <= 1'b1;
        end
    end

    assign cfg.xor_strap  = xor_r;
    assign cfg.allz_strap = allz_r;
    assign cfg.freq_strap = freq_r;
    assign cfg.qd_strap   = qd_r;
    // Test mode lasts only while the strap is still held high
    assign cfg.xor_active = xor_r & strap_xor_test;
    assign cfg.cold       = (state_r == RSL_ST_COLD);
    assign cfg.valid      = (state_r == RSL_ST_RUN) & qd_locked_r;

endmodule // rsl_strap_capture
`default_nettype wire

// [src/rsl_avmm_regs.sv]
// Avalon-MM slave holding the status, control and config registers
`timescale 1ns/100ps
`default_nettype none
module rsl_avmm_regs
    import rsl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Avalon-MM slave
    input  wire logic [RSL_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [RSL_DATA_W-1:0] avs_writedata,
    output logic      [RSL_DATA_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    // Latched options and control
    rsl_cfg_if.dst                     cfg,
    output logic                       ctrl_drive
);

    logic                  ack_r;
    logic [RSL_DATA_W-1:0] ctrl_r;
    logic [RSL_DATA_W-1:0] rdata_nxt;
    logic                  req;

    assign req             = avs_read | avs_write;
    // One wait cycle so read data always come from a flop
    assign avs_waitrequest = req & ~ack_r;
    assign ctrl_drive      = ctrl_r[RSL_CTRL_DRIVE_BIT];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_comb begin
        rdata_nxt = '0;
        unique case (avs_address)
            RSL_REG_STATUS_OFS: begin
                rdata_nxt[RSL_STAT_XOR_BIT]   = cfg.xor_strap;
                rdata_nxt[RSL_STAT_ALLZ_BIT]  = cfg.allz_strap;
                rdata_nxt[RSL_STAT_FREQ_BIT]  = cfg.freq_strap;
                rdata_nxt[RSL_STAT_QD_BIT]    = cfg.qd_strap;
                rdata_nxt[RSL_STAT_VALID_BIT] = cfg.valid;
                rdata_nxt[RSL_STAT_XACT_BIT]  = cfg.xor_active;
                rdata_nxt[RSL_STAT_COLD_BIT]  = cfg.cold;
            end
            RSL_REG_CTRL_OFS: begin
                rdata_nxt = ctrl_r;
            end
            RSL_REG_CONFIG_OFS: begin
                rdata_nxt[RSL_CFG_QD_LSB +: RSL_QD_W] = rsl_depth(cfg.qd_strap);
                rdata_nxt[RSL_CFG_MHZ_LSB +: 8] = rsl_host_mhz(cfg.freq_strap);
            end
            default: begin
                rdata_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rdata_nxt;
        end
    end

    // Only the drive bit is writable
    // Commit on the edge where waitrequest is already low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_r <= RSL_CTRL_RESET;
        end else if (avs_write && ack_r
                     && avs_address == RSL_REG_CTRL_OFS) begin
            ctrl_r[RSL_CTRL_DRIVE_BIT] <= avs_writedata[RSL_CTRL_DRIVE_BIT];
        end
    end

endmodule // rsl_avmm_regs
`default_nettype wire

// [src/rsl_strap_loader.sv]
// Top of the power-up strap option loader
// How it works
// - Straps other than depth load during cold reset, set configuration.
// - Test strap high in reset enters XOR test.
// - All-Z strap floats every output during reset.
// - Frequency strap: 0 is 66, 1 is 100 MHz.
// - Depth strap: 0 gives four, 1 gives one.
// - Depth strap caught at processor reset rising edge.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module rsl_strap_loader
    import rsl_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Board resets
    input  wire logic                  global_reset_n,
    input  wire logic                  processor_reset_n,
    // Strap pins
    input  wire logic                  strap_xor_test,
    input  wire logic                  strap_all_z,
    input  wire logic                  strap_host_freq,
    input  wire logic                  strap_queue_depth,
    // Avalon-MM slave
    input  wire logic [RSL_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [RSL_DATA_W-1:0] avs_writedata,
    output logic      [RSL_DATA_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    // Applied configuration
    output logic                       xor_tree_mode,
    output logic                       outputs_enable,
    output logic                       host_freq_100,
    output logic      [7:0]            host_freq_mhz,
    output logic      [RSL_QD_W-1:0]   in_order_queue_depth,
    output logic                       config_valid
);

    rsl_cfg_if cfg ();

    logic ctrl_drive;
    logic all_z_now;

    rsl_strap_capture u_capture (
        .clk_sys           (clk_sys),
        .reset             (reset),
        .global_reset_n    (global_reset_n),
        .processor_reset_n (processor_reset_n),
        .strap_xor_test    (strap_xor_test),
        .strap_all_z       (strap_all_z),
        .strap_host_freq   (strap_host_freq),
        .strap_queue_depth (strap_queue_depth),
        .cfg               (cfg.src)
    );

    rsl_avmm_regs u_regs (
        .clk_sys         (clk_sys),
        .reset           (reset),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .cfg             (cfg.dst),
        .ctrl_drive      (ctrl_drive)
    );

    // Live strap: float only while the global reset is held
    assign all_z_now = ~global_reset_n & strap_all_z;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            outputs_enable <= 1'b0;
        end else begin
            outputs_enable <= ~all_z_now & ctrl_drive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xor_tree_mode <= 1'b0;
        end else begin
            xor_tree_mode <= cfg.xor_active;
        end
    end

    // Host clock itself comes from outside; only the rate is reported
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            host_freq_100 <= RSL_STRAP_RESET;
            host_freq_mhz <= rsl_host_mhz(RSL_STRAP_RESET);
        end else begin
            host_freq_100 <= cfg.freq_strap;
            host_freq_mhz <= rsl_host_mhz(cfg.freq_strap);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            in_order_queue_depth <= rsl_depth(RSL_STRAP_RESET);
            config_valid         <= 1'b0;
        end else begin
            in_order_queue_depth <= rsl_depth(cfg.qd_strap);
            config_valid         <= cfg.valid;
        end
    end

endmodule // rsl_strap_loader
`default_nettype wire

// [bench/rsl_props.sv]
// Port-level assertions for the strap option loader
`timescale 1ns/100ps
`default_nettype none
module rsl_props
    import rsl_pkg::*;
(
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                reset,
    // Board side
    input wire logic                global_reset_n,
    input wire logic                processor_reset_n,
    input wire logic                strap_xor_test,
    input wire logic                strap_all_z,
    input wire logic                strap_host_freq,
    // Applied configuration
    input wire logic                xor_tree_mode,
    input wire logic                outputs_enable,
    input wire logic                host_freq_100,
    input wire logic [7:0]          host_freq_mhz,
    input wire logic [RSL_QD_W-1:0] in_order_queue_depth,
    input wire logic                config_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    mhz_decode_a: assert property (host_freq_mhz ==
        (host_freq_100 ? 8'h64 : 8'h42)) else $error("host MHz mismatch");
    freq_sample_a: assert property (!global_reset_n |-> ##2
        host_freq_100 == $past(strap_host_freq, 2))
        else $error("frequency strap not applied");
    depth_legal_a: assert property (in_order_queue_depth
        inside {3'h4, 3'h1}) else $error("illegal queue depth");
    allz_float_a: assert property (!global_reset_n && strap_all_z
        |=> !outputs_enable) else $error("outputs driven in all-Z reset");
    xor_strap_a: assert property (!strap_xor_test
        |=> !xor_tree_mode) else $error("test mode without strap");
    cold_clear_a: assert property (!global_reset_n
        |-> ##2 !config_valid) else $error("valid during cold reset");
    valid_edge_a: assert property ($rose(config_valid)
        |-> processor_reset_n && global_reset_n)
        else $error("valid without processor reset release");
    hold_latch_a: assert property (config_valid && $past(config_valid)
        && global_reset_n && $past(global_reset_n, 2)
        |-> $stable(host_freq_100) && $stable(in_order_queue_depth))
        else $error("latched option changed");

    cover property ($rose(config_valid));
    cover property (xor_tree_mode);
    cover property (!global_reset_n && strap_all_z ##1 !outputs_enable);
endmodule // rsl_props

bind rsl_strap_loader rsl_props rsl_props_inst (.clk_sys, .reset,
    .global_reset_n, .processor_reset_n, .strap_xor_test, .strap_all_z,
    .strap_host_freq, .xor_tree_mode, .outputs_enable, .host_freq_100,
    .host_freq_mhz, .in_order_queue_depth, .config_valid);
`default_nettype wire

// [bench/rsl_board_model.sv]
// Board strap resistors and hub cold-reset driver
`timescale 1ns/100ps
`default_nettype none
module rsl_board_model
    import rsl_pkg::*;
(
    // Clock
    input  wire logic clk_sys,
    // Hub reset and requested strap levels
    input  wire logic hub_pci_reset_n,
    input  wire logic want_xor,
    input  wire logic want_allz,
    input  wire logic want_freq,
    input  wire logic want_qd,
    // To the loader
    output var  logic global_reset_n,
    output wire logic strap_xor_test,
    output wire logic strap_all_z,
    output wire logic strap_host_freq,
    output wire logic strap_queue_depth,
    // Host clock rate the board generator runs at
    output wire logic [7:0] host_clk_mhz
);
    // Hub retimes its reset, so cold reset lags by one cycle
    always_ff @(posedge clk_sys) begin
        global_reset_n <= hub_pci_reset_n;
    end
    // Resistors hold each level for as long as the board asks
    assign strap_xor_test    = want_xor;
    assign strap_all_z       = want_allz;
    assign strap_host_freq   = want_freq;
    assign strap_queue_depth = want_qd;
    // Clock source follows the same strap choice as the loader
    assign host_clk_mhz = want_freq ? RSL_HOST_MHZ_FAST
                                    : RSL_HOST_MHZ_SLOW;
endmodule // rsl_board_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the strap option loader
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rsl_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        hub_pci_reset_n = 1'b0;
    logic        processor_reset_n = 1'b0;
    logic        wx = 1'b0, wa = 1'b0, wf = 1'b0, wq = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, xor_tree_mode, outputs_enable;
    logic        host_freq_100, config_valid;
    logic [7:0]  host_freq_mhz;
    logic [2:0]  in_order_queue_depth;
    wire         global_reset_n, strap_xor_test, strap_all_z;
    wire         strap_host_freq, strap_queue_depth;
    wire [7:0]   host_clk_mhz;
    int          n_errors = 0, n_checks = 0;

    rsl_board_model rsl_board_model_inst (.clk_sys, .hub_pci_reset_n,
        .want_xor(wx), .want_allz(wa), .want_freq(wf), .want_qd(wq),
        .global_reset_n, .strap_xor_test, .strap_all_z,
        .strap_host_freq, .strap_queue_depth, .host_clk_mhz);
    rsl_strap_loader rsl_strap_loader_inst (.clk_sys, .reset,
        .global_reset_n, .processor_reset_n, .strap_xor_test,
        .strap_all_z, .strap_host_freq, .strap_queue_depth, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .xor_tree_mode, .outputs_enable, .host_freq_100,
        .host_freq_mhz, .in_order_queue_depth, .config_valid);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One Avalon request; waitrequest and data taken at the rising edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_errors++;
            summarize();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic boot(input logic x, a, f, q);
        int i;
        @(posedge clk_sys);
        hub_pci_reset_n <= 1'b0;
        processor_reset_n <= 1'b0;
        {wx, wa, wf, wq} <= {x, a, f, q};
        repeat (4) @(posedge clk_sys);
        #1 chk("oe_cold", {31'h0, !a}, {31'h0, outputs_enable});
        // Status while cold: straps follow, depth cleared, cold flag up
        bus(1'b0, RSL_REG_STATUS_OFS, 32'h0);
        chk("st_cold", {25'h0, 1'b1, x, 2'b00, f, a, x}, rd);
        @(posedge clk_sys) hub_pci_reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        processor_reset_n <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            #1;
            if (config_valid === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            summarize();
        end
        chk("freq100", {31'h0, f}, {31'h0, host_freq_100});
        chk("mhz", f ? 32'h64 : 32'h42, {24'h0, host_freq_mhz});
        chk("hclk", {24'h0, host_clk_mhz}, {24'h0, host_freq_mhz});
        chk("depth", q ? 32'h1 : 32'h4, {29'h0, in_order_queue_depth});
        chk("xor", {31'h0, x}, {31'h0, xor_tree_mode});
        chk("oe_run", 32'h1, {31'h0, outputs_enable});
    endtask

    // Registers after a boot with every strap at 1
    task automatic regs();
        bus(1'b0, RSL_REG_CTRL_OFS, 32'h0);
        chk("ctrl_rst", RSL_CTRL_RESET, rd);
        bus(1'b1, RSL_REG_STATUS_OFS, 32'h0);
        bus(1'b1, RSL_REG_CONFIG_OFS, 32'h0);
        bus(1'b0, RSL_REG_STATUS_OFS, 32'h0);
        chk("status", 32'h3F, rd);
        bus(1'b0, RSL_REG_CONFIG_OFS, 32'h0);
        chk("config", 32'h6401, rd);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, RSL_REG_CTRL_OFS, 32'h0);
        @(posedge clk_sys) #1 chk("oe_off", 32'h0, {31'h0, outputs_enable});
        bus(1'b1, RSL_REG_CTRL_OFS, 32'h1);
        @(posedge clk_sys) #1 chk("oe_on", 32'h1, {31'h0, outputs_enable});
    endtask

    // Warm processor reset with new straps changes nothing
    task automatic warm();
        @(posedge clk_sys);
        {wf, wq} <= 2'b00;
        processor_reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        processor_reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk("warm_freq", 32'h1, {31'h0, host_freq_100});
        chk("warm_depth", 32'h1, {29'h0, in_order_queue_depth});
        chk("warm_valid", 32'h1, {31'h0, config_valid});
    endtask

    // Test mode lasts only while the strap is held
    task automatic xor_drop();
        @(posedge clk_sys) wx <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk("xor_end", 32'h0, {31'h0, xor_tree_mode});
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        boot(1'b0, 1'b0, 1'b0, 1'b0);
        boot(1'b1, 1'b1, 1'b1, 1'b1);
        regs();
        warm();
        xor_drop();
        boot(1'b0, 1'b1, 1'b1, 1'b0);
        summarize();
    end
endmodule // testbench
`default_nettype wire
